/* logic/i2cev_top.sv */
/*
  Event status block of a two-wire controller: sticky completion, arbitration
  and bus fault flags, deferred slave request notification with clock
  stretching, collision back-off and retry, AXI4-Lite register access.
  Assumes the transfer engine on the same clock reports transaction ends,
  addressing and the levels it wants on the pins; pins are open drain.
*/
// Added by the designer: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/100ps
module i2cev_top
  import i2cev_pkg::*;
(
  input wire logic clock_in,
  input wire logic reset_in,
  input wire logic [REG_AW-1:0] axi_awaddr_in,
  input wire logic axi_awvalid_in,
  output logic axi_awready_out,
  input wire logic [31:0] axi_wdata_in,
  input wire logic [3:0] axi_wstrb_in,
  input wire logic axi_wvalid_in,
  output logic axi_wready_out,
  output logic [1:0] axi_bresp_out,
  output logic axi_bvalid_out,
  input wire logic axi_bready_in,
  input wire logic [REG_AW-1:0] axi_araddr_in,
  input wire logic axi_arvalid_in,
  output logic axi_arready_out,
  output logic [31:0] axi_rdata_out,
  output logic [1:0] axi_rresp_out,
  output logic axi_rvalid_out,
  input wire logic axi_rready_in,
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe_out,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_out,
  input wire logic master_end_in,
  input wire logic slave_end_in,
  input wire logic master_busy_in,
  input wire logic slave_busy_in,
  input wire logic addr_read_in,
  input wire logic addr_write_in,
  input wire logic tx_write_in,
  input wire logic own_cond_in,
  input wire logic sda_release_in,
  input wire logic sda_low_req_in,
  input wire logic scl_low_req_in,
  output logic cmd_go_out,
  output logic cmd_stop_out,
  output logic retry_out,
  output logic abort_master_out,
  output logic abort_slave_out,
  output logic tx_flush_out,
  output logic irq_out
);
  function automatic logic [31:0] strb_bits(input logic [3:0] strb);
    strb_bits = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
  endfunction
  logic scl_f, sda_f, start_det, stop_det, scl_rise;
  i2cev_sync #(.RESET_VAL(1'b1)) u_scl_sync (
    .clock_in(clock_in), .reset_in(reset_in), .pin_in(scl_in), .level_out(scl_f)
  );
  i2cev_sync #(.RESET_VAL(1'b1)) u_sda_sync (
    .clock_in(clock_in), .reset_in(reset_in), .pin_in(sda_in), .level_out(sda_f)
  );
  i2cev_cond u_cond (
    .clock_in(clock_in), .reset_in(reset_in), .scl_in(scl_f), .sda_in(sda_f),
    .start_out(start_det), .stop_out(stop_det), .scl_rise_out(scl_rise)
  );
  logic aw_hold_q, aw_hold_d, w_hold_q, w_hold_d, bvalid_q, bvalid_d, rvalid_q, rvalid_d;
  logic [REG_AW-1:0] awaddr_q, awaddr_d;
  logic [31:0] wdata_q, wdata_d, rdata_q, rdata_d, wbits, clr;
  logic [3:0] wstrb_q, wstrb_d;
  logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
  logic wr_go;
  assign axi_awready_out = ~aw_hold_q & ~bvalid_q;
  assign axi_wready_out = ~w_hold_q & ~bvalid_q;
  assign axi_arready_out = ~rvalid_q;
  assign wr_go = aw_hold_q & w_hold_q & ~bvalid_q;
  assign wbits = wdata_q & strb_bits(wstrb_q);
  logic [31:0] status_q, status_d, mask_q, mask_d, set;
  logic [ERROR_FIELD_A_W-1:0] error_field_a_q, error_field_a_d;
  logic stop_bit_q, stop_bit_d, go_q, go_d;
  logic rd_pend_q, rd_pend_d, wr_pend_q, wr_pend_d;
  logic retry_pend_q, retry_pend_d, retry_q, retry_d;
  logic flush_q, flush_d, abm_q, abm_d, abs_q, abs_d, irq_q, irq_d;
  logic scl_oe_q, scl_oe_d, sda_oe_q, sda_oe_d;
  i2cev_arb_e arb_q, arb_d;
  logic done_any, collide, fault, rd_note, wr_note;
  assign done_any = status_q[BIT_MDONE] | status_q[BIT_SDONE] | status_q[BIT_MNOSTOP];
  assign collide = scl_rise & sda_release_in & ~sda_f & (arb_q == ARB_LIVE);
  assign fault = (start_det | stop_det) & (master_busy_in | slave_busy_in) & ~own_cond_in;
  assign rd_note = rd_pend_q & ~done_any;
  assign wr_note = wr_pend_q & ~done_any;
  always_comb begin
    aw_hold_d = aw_hold_q;
    w_hold_d = w_hold_q;
    awaddr_d = awaddr_q;
    wdata_d = wdata_q;
    wstrb_d = wstrb_q;
    bvalid_d = bvalid_q;
    bresp_d = bresp_q;
    rvalid_d = rvalid_q;
    rdata_d = rdata_q;
    rresp_d = rresp_q;
    if (axi_awvalid_in && axi_awready_out) begin
      aw_hold_d = 1'b1;
      awaddr_d = axi_awaddr_in;
    end
    if (axi_wvalid_in && axi_wready_out) begin
      w_hold_d = 1'b1;
      wdata_d = axi_wdata_in;
      wstrb_d = axi_wstrb_in;
    end
    if (wr_go) begin
      aw_hold_d = 1'b0;
      w_hold_d = 1'b0;
      bvalid_d = 1'b1;
      bresp_d = ((awaddr_q == OFS_STATUS) || (awaddr_q == OFS_MASK) || (awaddr_q == OFS_CLEAR) ||
                 (awaddr_q == OFS_XSTAT) || (awaddr_q == OFS_MCMD)) ? RESP_OKAY : RESP_SLVERR;
    end else if (bvalid_q && axi_bready_in) begin
      bvalid_d = 1'b0;
    end
    if (axi_arvalid_in && axi_arready_out) begin
      rvalid_d = 1'b1;
      rresp_d = RESP_OKAY;
      unique case (axi_araddr_in)
        OFS_STATUS: rdata_d = status_q;
        OFS_MASK: rdata_d = mask_q;
        OFS_CLEAR: rdata_d = 32'h0000_0000;
        OFS_XSTAT: rdata_d = {{(32-ERROR_FIELD_A_W){1'b0}}, error_field_a_q};
        OFS_MCMD: rdata_d = {30'h0000_0000, stop_bit_q, 1'b0};
        default: begin
          rdata_d = 32'h0000_0000;
          rresp_d = RESP_SLVERR;
        end
      endcase
    end else if (rvalid_q && axi_rready_in) begin
      rvalid_d = 1'b0;
    end
  end
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      aw_hold_q <= 1'b0;
      w_hold_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= RESP_OKAY;
    end else begin
      aw_hold_q <= aw_hold_d;
      w_hold_q <= w_hold_d;
      awaddr_q <= awaddr_d;
      wdata_q <= wdata_d;
      wstrb_q <= wstrb_d;
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
      rvalid_q <= rvalid_d;
      rdata_q <= rdata_d;
      rresp_q <= rresp_d;
    end
  end
  always_comb begin
    set = 32'h0000_0000;
    set[BIT_MDONE] = master_end_in & stop_bit_q;
    set[BIT_MNOSTOP] = master_end_in & ~stop_bit_q;
    set[BIT_SDONE] = slave_end_in;
    set[BIT_SARB] = collide & slave_busy_in;
    set[BIT_MARB] = collide & master_busy_in;
    set[BIT_BFAULT] = fault;
    set[BIT_RDREQ] = rd_note;
    set[BIT_WRREQ] = wr_note;
    clr = (wr_go && awaddr_q == OFS_CLEAR) ? wbits : 32'h0000_0000;
    clr[BIT_RDREQ] = clr[BIT_RDREQ] | tx_write_in;
    // Set wins over a clear in the same cycle
    status_d = ((status_q & ~clr) | set) & STATUS_IMPL;
    mask_d = (wr_go && awaddr_q == OFS_MASK) ?
             ((mask_q & ~strb_bits(wstrb_q)) | wbits) & STATUS_IMPL : mask_q;
    irq_d = |(status_d & mask_d);
    error_field_a_d = error_field_a_q;
    // master arbitration error_field_a outranks a coincident bus fault
    if (set[BIT_MARB]) begin
      error_field_a_d = ERROR_FIELD_A_ARB;
    end else if (fault) begin
      error_field_a_d = ERROR_FIELD_A_BUS;
    end else if (master_end_in || slave_end_in) begin
      error_field_a_d = ERROR_FIELD_A_OK;
    end
    rd_pend_d = (rd_pend_q & ~rd_note) | addr_read_in;
    wr_pend_d = (wr_pend_q & ~wr_note) | addr_write_in;
    flush_d = rd_note;
    abm_d = fault & master_busy_in;
    abs_d = fault & slave_busy_in;
    stop_bit_d = stop_bit_q;
    go_d = 1'b0;
    // commands are refused while a completion awaits acknowledgment
    if (wr_go && awaddr_q == OFS_MCMD && wstrb_q[0] && !done_any) begin
      stop_bit_d = wdata_q[MCMD_STOP];
      go_d = wdata_q[MCMD_GO];
    end
    arb_d = arb_q;
    retry_pend_d = retry_pend_q;
    retry_d = 1'b0;
    unique case (arb_q)
      ARB_LIVE: begin
        // stop driving and wait for the bus to go idle
        if (collide) begin
          arb_d = ARB_BACKOFF;
          retry_pend_d = master_busy_in;
        end
      end
      ARB_BACKOFF: begin
        // retry a lost master transfer once a stop is seen
        if (stop_det) begin
          arb_d = ARB_LIVE;
          retry_d = retry_pend_q;
          retry_pend_d = 1'b0;
        end
      end
    endcase
    sda_oe_d = sda_low_req_in & (arb_d == ARB_LIVE);
    // stretch the clock while a request is held back
    scl_oe_d = scl_low_req_in | (done_any & (rd_pend_d | wr_pend_d));
  end
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      status_q <= STATUS_RST;
      mask_q <= MASK_RST;
      error_field_a_q <= ERROR_FIELD_A_OK;
      stop_bit_q <= 1'b0;
      go_q <= 1'b0;
      rd_pend_q <= 1'b0;
      wr_pend_q <= 1'b0;
      retry_pend_q <= 1'b0;
      retry_q <= 1'b0;
      flush_q <= 1'b0;
      abm_q <= 1'b0;
      abs_q <= 1'b0;
      irq_q <= 1'b0;
      scl_oe_q <= 1'b0;
      sda_oe_q <= 1'b0;
      arb_q <= ARB_LIVE;
    end else begin
      status_q <= status_d;
      mask_q <= mask_d;
      error_field_a_q <= error_field_a_d;
      stop_bit_q <= stop_bit_d;
      go_q <= go_d;
      rd_pend_q <= rd_pend_d;
      wr_pend_q <= wr_pend_d;
      retry_pend_q <= retry_pend_d;
      retry_q <= retry_d;
      flush_q <= flush_d;
      abm_q <= abm_d;
      abs_q <= abs_d;
      irq_q <= irq_d;
      scl_oe_q <= scl_oe_d;
      sda_oe_q <= sda_oe_d;
      arb_q <= arb_d;
    end
  end
  assign axi_bvalid_out = bvalid_q;
  assign axi_bresp_out = bresp_q;
  assign axi_rvalid_out = rvalid_q;
  assign axi_rdata_out = rdata_q;
  assign axi_rresp_out = rresp_q;
  // Open drain: only ever pull low
  assign scl_out = 1'b0;
  assign sda_out = 1'b0;
  assign scl_oe_out = scl_oe_q;
  assign sda_oe_out = sda_oe_q;
  assign cmd_go_out = go_q;
  assign cmd_stop_out = stop_bit_q;
  assign retry_out = retry_q;
  assign abort_master_out = abm_q;
  assign abort_slave_out = abs_q;
  assign tx_flush_out = flush_q;
  assign irq_out = irq_q;
  a_mdone_set: assert property (@(posedge clock_in) disable iff (reset_in)
    master_end_in && stop_bit_q |=> status_q[BIT_MDONE]) else $error("master done unset");
  a_nostop_set: assert property (@(posedge clock_in) disable iff (reset_in)
    master_end_in && !stop_bit_q |=> status_q[BIT_MNOSTOP])
    else $error("done without stop flag not set");
  a_sdone_set: assert property (@(posedge clock_in) disable iff (reset_in)
    slave_end_in |=> status_q[BIT_SDONE]) else $error("slave done flag not set");
  a_req_held: assert property (@(posedge clock_in) disable iff (reset_in)
    $rose(status_q[BIT_RDREQ]) || $rose(status_q[BIT_WRREQ]) |-> !$past(done_any))
    else $error("request flagged while done pending");
  a_scl_stretch: assert property (@(posedge clock_in) disable iff (reset_in)
    done_any && (addr_read_in || addr_write_in) |=> scl_oe_out)
    else $error("clock not stretched");
  a_flush_req: assert property (@(posedge clock_in) disable iff (reset_in)
    $rose(status_q[BIT_RDREQ]) |-> tx_flush_out ##1 !tx_flush_out)
    else $error("no transmit flush with read request");
  a_sda_backoff: assert property (@(posedge clock_in) disable iff (reset_in)
    collide |=> !sda_oe_out && arb_q == ARB_BACKOFF)
    else $error("data still driven after collision");
  a_marb_error_field_a: assert property (@(posedge clock_in) disable iff (reset_in)
    collide && master_busy_in |=> status_q[BIT_MARB] && error_field_a_q == ERROR_FIELD_A_ARB)
    else $error("master arbitration loss not recorded");
  a_sarb_set: assert property (@(posedge clock_in) disable iff (reset_in)
    collide && slave_busy_in |=> status_q[BIT_SARB])
    else $error("slave arbitration loss not set");
  a_retry_stop: assert property (@(posedge clock_in) disable iff (reset_in)
    arb_q == ARB_BACKOFF && stop_det && retry_pend_q |=> retry_out ##1 !retry_out)
    else $error("no retry after stop");
  a_bfault_set: assert property (@(posedge clock_in) disable iff (reset_in)
    fault && !(collide && master_busy_in) |=> status_q[BIT_BFAULT] && error_field_a_q == ERROR_FIELD_A_BUS)
    else $error("bus fault not recorded");
  a_flag_sticky: assert property (@(posedge clock_in) disable iff (reset_in)
    status_q[BIT_MARB] && !(wr_go && awaddr_q == OFS_CLEAR && wbits[BIT_MARB])
    |=> status_q[BIT_MARB]) else $error("flag cleared without write");
endmodule // i2cev_top

/* logic/i2cev_pkg.sv */
/*
  Constants for the two-wire event status block: register offsets, flag
  positions, error_field_a codes, reset values and AXI4-Lite responses.
  Assumes a 32-bit AXI4-Lite bus with word-aligned byte addresses.
*/
package i2cev_pkg;
  localparam int REG_AW = 8;
  localparam logic [REG_AW-1:0] OFS_STATUS = 8'h00;
  localparam logic [REG_AW-1:0] OFS_MASK = 8'h04;
  localparam logic [REG_AW-1:0] OFS_CLEAR = 8'h08;
  localparam logic [REG_AW-1:0] OFS_XSTAT = 8'h0c;
  localparam logic [REG_AW-1:0] OFS_MCMD = 8'h10;

  localparam int BIT_RDREQ = 16;
  localparam int BIT_WRREQ = 18;
  localparam int BIT_MDONE = 19;
  localparam int BIT_SDONE = 20;
  localparam int BIT_SARB = 23;
  localparam int BIT_MARB = 24;
  localparam int BIT_BFAULT = 25;
  localparam int BIT_MNOSTOP = 28;
  localparam logic [31:0] STATUS_IMPL = 32'h139d_0000;
  localparam logic [31:0] STATUS_RST = 32'h0000_0000;
  localparam logic [31:0] MASK_RST = 32'h0000_0000;

  // Master command: bit 0 starts a transaction, bit 1 requests a stop
  localparam int MCMD_GO = 0;
  localparam int MCMD_STOP = 1;

  localparam int ERROR_FIELD_A_W = 3;
  localparam logic [ERROR_FIELD_A_W-1:0] ERROR_FIELD_A_OK = 3'h0;
  localparam logic [ERROR_FIELD_A_W-1:0] ERROR_FIELD_A_ARB = 3'h1;
  localparam logic [ERROR_FIELD_A_W-1:0] ERROR_FIELD_A_BUS = 3'h2;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic {
    ARB_LIVE = 1'b0,
    ARB_BACKOFF = 1'b1
  } i2cev_arb_e;
endpackage

/* logic/i2cev_sync.sv */
/*
  Three-stage synchroniser with agreement filter for one pin.
  Assumes the input is asynchronous to clock_in.
*/
`timescale 1ns/100ps
module i2cev_sync #(
  parameter logic RESET_VAL = 1'b1
) (
  input wire logic clock_in,
  input wire logic reset_in,
  input wire logic pin_in,
  output logic level_out
);
  logic q1_q, q2_q, q3_q, level_q;
  logic level_d;

  // Only the agreeing later stages may move the filtered level
  always_comb begin
    level_d = (q2_q == q3_q) ? q3_q : level_q;
  end

  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      q1_q <= RESET_VAL;
      q2_q <= RESET_VAL;
      q3_q <= RESET_VAL;
      level_q <= RESET_VAL;
    end else begin
      q1_q <= pin_in;
      q2_q <= q1_q;
      q3_q <= q2_q;
      level_q <= level_d;
    end
  end

  assign level_out = level_q;
endmodule // i2cev_sync

/* logic/i2cev_cond.sv */
/*
  Bus condition detector: start, stop and clock rising edge from the
  filtered clock and data levels. Assumes both inputs are already synchronous.
*/
`timescale 1ns/100ps
module i2cev_cond (
  input wire logic clock_in,
  input wire logic reset_in,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic start_out,
  output logic stop_out,
  output logic scl_rise_out
);
  logic scl_prev_q, sda_prev_q;

  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      scl_prev_q <= 1'b1;
      sda_prev_q <= 1'b1;
    end else begin
      scl_prev_q <= scl_in;
      sda_prev_q <= sda_in;
    end
  end

  // Data may only move with the clock high to form a condition
  assign start_out = scl_in & scl_prev_q & sda_prev_q & ~sda_in;
  assign stop_out = scl_in & scl_prev_q & ~sda_prev_q & sda_in;
  assign scl_rise_out = scl_in & ~scl_prev_q;
endmodule // i2cev_cond

/* testbench/i2cev_bus_peer.sv */
/*
  Behavioural far-side station on the two-wire bus: frames, bits, collisions.
  Assumes pull-ups on both lines; the block's enables pull them low.
*/
`timescale 1ns/100ps
module i2cev_bus_peer (
  input wire logic scl_oe_in,
  input wire logic sda_oe_in,
  output logic scl_out,
  output logic sda_out
);
  logic scl_pull;
  logic sda_pull;
  // Released lines float back to the pull-up level, never hold a stale value
  assign scl_out = !(scl_pull || scl_oe_in);
  assign sda_out = !(sda_pull || sda_oe_in);
  initial begin
    scl_pull = 1'b0;
    sda_pull = 1'b0;
  end
  task automatic start_frame();
    sda_pull <= 1'b1;
    #200;
    scl_pull <= 1'b1;
    #200;
  endtask
  // a pulled-low bit beats a released one
  task automatic send_bit(input logic v);
    sda_pull <= !v;
    #200;
    scl_pull <= 1'b0;
    #200;
    scl_pull <= 1'b1;
  endtask
  // Clock stays high after the stop, so it stands still between frames
  task automatic stop_frame();
    sda_pull <= 1'b1;
    #200;
    scl_pull <= 1'b0;
    #200;
    sda_pull <= 1'b0;
    #200;
  endtask
endmodule // i2cev_bus_peer

/* testbench/i2c_event_status_upper_tb.sv */
/*
  Self-checking bench for the event status block: AXI4-Lite tasks, engine
  event pulses and a far-side bus station. Assumes the package constants.
*/
`timescale 1ns/100ps
module i2c_event_status_upper_tb
  import i2cev_pkg::*;
;
  logic clock_in = 1'b0;
  logic reset_in = 1'b1;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic scl_line, sda_line, scl_oe, sda_oe, scl_drv, sda_drv;
  logic [4:0] ev;
  logic mbusy, sbusy, rel, own_cond, sda_low, scl_low;
  logic cmd_go, cmd_stop, retry, abort_m, abort_s, tx_flush, irq;
  logic [4:0] seen;
  int n_mismatch = 0;
  int n_compared = 0;
  int cycles = 0;

  always #25 clock_in = !clock_in;

  i2cev_top i_dut (.clock_in(clock_in), .reset_in(reset_in),
    .axi_awaddr_in(awaddr), .axi_awvalid_in(awvalid), .axi_awready_out(awready),
    .axi_wdata_in(wdata), .axi_wstrb_in(wstrb), .axi_wvalid_in(wvalid),
    .axi_wready_out(wready), .axi_bresp_out(bresp), .axi_bvalid_out(bvalid),
    .axi_bready_in(bready), .axi_araddr_in(araddr), .axi_arvalid_in(arvalid),
    .axi_arready_out(arready), .axi_rdata_out(rdata), .axi_rresp_out(rresp),
    .axi_rvalid_out(rvalid), .axi_rready_in(rready), .scl_in(scl_line),
    .scl_out(scl_drv), .scl_oe_out(scl_oe), .sda_in(sda_line), .sda_out(sda_drv),
    .sda_oe_out(sda_oe), .master_end_in(ev[0]), .slave_end_in(ev[1]),
    .master_busy_in(mbusy), .slave_busy_in(sbusy), .addr_read_in(ev[2]),
    .addr_write_in(ev[3]), .tx_write_in(ev[4]), .own_cond_in(own_cond),
    .sda_release_in(rel), .sda_low_req_in(sda_low), .scl_low_req_in(scl_low),
    .cmd_go_out(cmd_go), .cmd_stop_out(cmd_stop), .retry_out(retry),
    .abort_master_out(abort_m), .abort_slave_out(abort_s),
    .tx_flush_out(tx_flush), .irq_out(irq));

  i2cev_bus_peer i_peer (.scl_oe_in(scl_oe), .sda_oe_in(sda_oe),
    .scl_out(scl_line), .sda_out(sda_line));

  // Pulses are remembered so one-cycle outputs are never missed
  always @(posedge clock_in) begin
    if (reset_in) seen <= 5'h0;
    else seen <= seen | {cmd_go, retry, abort_m, abort_s, tx_flush};
  end

  task automatic results();
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  always @(posedge clock_in) begin
    cycles++;
    if (cycles == 20000) begin
      n_mismatch++;
      results();
    end
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t got %h expected %h", $time, got, exp);
    end
  endtask

  function automatic logic [31:0] bitv(input int b);
    return 32'h1 << b;
  endfunction

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic ta, tw, an, wn;
    ta = 1'b0;
    tw = 1'b0;
    @(posedge clock_in);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hf;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(negedge clock_in);
      an = awvalid && awready;
      wn = wvalid && wready;
      @(posedge clock_in);
      if (an) begin
        awvalid <= 1'b0;
        ta = 1'b1;
      end
      if (wn) begin
        wvalid <= 1'b0;
        tw = 1'b1;
      end
    end while (!(ta && tw));
    do @(negedge clock_in); while (!bvalid);
    check({30'h0, bresp}, {30'h0, er});
    @(posedge clock_in);
    bready <= 1'b0;
  endtask

  task automatic cr(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
    @(posedge clock_in);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(negedge clock_in); while (!arready);
    @(posedge clock_in);
    arvalid <= 1'b0;
    do @(negedge clock_in); while (!rvalid);
    check(rdata, exp);
    check({30'h0, rresp}, {30'h0, er});
    @(posedge clock_in);
    rready <= 1'b0;
  endtask

  task automatic ticks(input int n);
    repeat (n) @(posedge clock_in);
  endtask

  task automatic pulse(input int k);
    @(posedge clock_in);
    ev <= 5'h1 << k;
    @(posedge clock_in);
    ev <= 5'h0;
    ticks(2);
  endtask

  task automatic levels(input logic m, input logic s, input logic r);
    @(posedge clock_in);
    mbusy <= m;
    sbusy <= s;
    rel <= r;
  endtask

  initial begin
    {awaddr, araddr, wdata, wstrb, ev} = '0;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    {mbusy, sbusy, rel, own_cond, sda_low, scl_low} = '0;
    ticks(12);
    reset_in <= 1'b0;
    cr(OFS_STATUS, 32'h0, RESP_OKAY);
    cr(OFS_XSTAT, 32'h0, RESP_OKAY);
    check({30'h0, scl_drv, sda_drv}, 32'h0);
    cr(8'h40, 32'h0, RESP_SLVERR);
    wr(8'h40, 32'h1, RESP_SLVERR);
    wr(OFS_MCMD, 32'h3, RESP_OKAY);
    check({31'h0, cmd_stop}, 32'h1);
    pulse(0);
    cr(OFS_STATUS, bitv(BIT_MDONE), RESP_OKAY);
    check({31'h0, irq}, 32'h0);
    wr(OFS_MASK, bitv(BIT_MDONE), RESP_OKAY);
    ticks(2);
    check({31'h0, irq}, 32'h1);
    wr(OFS_STATUS, 32'hffff_ffff, RESP_OKAY);
    wr(OFS_CLEAR, bitv(BIT_SDONE), RESP_OKAY);
    cr(OFS_STATUS, bitv(BIT_MDONE), RESP_OKAY);
    wr(OFS_MCMD, 32'h1, RESP_OKAY);
    check({31'h0, cmd_stop}, 32'h1);
    wr(OFS_CLEAR, bitv(BIT_MDONE), RESP_OKAY);
    ticks(2);
    check({31'h0, irq}, 32'h0);
    wr(OFS_MCMD, 32'h1, RESP_OKAY);
    check({31'h0, cmd_stop}, 32'h0);
    check({31'h0, seen[4]}, 32'h1);
    pulse(0);
    cr(OFS_STATUS, bitv(BIT_MNOSTOP), RESP_OKAY);
    wr(OFS_CLEAR, bitv(BIT_MNOSTOP), RESP_OKAY);
    pulse(1);
    cr(OFS_STATUS, bitv(BIT_SDONE), RESP_OKAY);
    pulse(2);
    check({31'h0, scl_oe}, 32'h1);
    cr(OFS_STATUS, bitv(BIT_SDONE), RESP_OKAY);
    wr(OFS_CLEAR, bitv(BIT_SDONE), RESP_OKAY);
    ticks(4);
    check({31'h0, scl_oe}, 32'h0);
    cr(OFS_STATUS, bitv(BIT_RDREQ), RESP_OKAY);
    check({31'h0, seen[0]}, 32'h1);
    pulse(4);
    cr(OFS_STATUS, 32'h0, RESP_OKAY);
    pulse(3);
    cr(OFS_STATUS, bitv(BIT_WRREQ), RESP_OKAY);
    wr(OFS_CLEAR, bitv(BIT_WRREQ), RESP_OKAY);
    // Slave loses a data bit while releasing the line
    i_peer.start_frame();
    levels(1'b0, 1'b1, 1'b1);
    sda_low <= 1'b1;
    ticks(2);
    check({31'h0, sda_oe}, 32'h1);
    i_peer.send_bit(1'b0);
    ticks(8);
    check({31'h0, sda_oe}, 32'h0);
    cr(OFS_STATUS, bitv(BIT_SARB), RESP_OKAY);
    levels(1'b0, 1'b0, 1'b0);
    sda_low <= 1'b0;
    i_peer.stop_frame();
    ticks(8);
    check({31'h0, seen[3]}, 32'h0);
    wr(OFS_CLEAR, bitv(BIT_SARB), RESP_OKAY);
    // Own start while busy as master is no bus fault
    own_cond <= 1'b1;
    levels(1'b1, 1'b0, 1'b1);
    i_peer.start_frame();
    i_peer.send_bit(1'b0);
    ticks(8);
    cr(OFS_STATUS, bitv(BIT_MARB), RESP_OKAY);
    cr(OFS_XSTAT, {29'h0, ERROR_FIELD_A_ARB}, RESP_OKAY);
    levels(1'b0, 1'b0, 1'b0);
    own_cond <= 1'b0;
    i_peer.stop_frame();
    ticks(8);
    check({31'h0, seen[3]}, 32'h1);
    wr(OFS_CLEAR, bitv(BIT_MARB), RESP_OKAY);
    // Foreign start during a master transfer, then stop during a slave one
    levels(1'b1, 1'b0, 1'b0);
    i_peer.start_frame();
    ticks(8);
    cr(OFS_STATUS, bitv(BIT_BFAULT), RESP_OKAY);
    cr(OFS_XSTAT, {29'h0, ERROR_FIELD_A_BUS}, RESP_OKAY);
    check({30'h0, seen[2:1]}, 32'h2);
    levels(1'b0, 1'b1, 1'b0);
    i_peer.stop_frame();
    ticks(8);
    check({31'h0, seen[1]}, 32'h1);
    levels(1'b0, 1'b0, 1'b0);
    wr(OFS_CLEAR, bitv(BIT_BFAULT), RESP_OKAY);
    cr(OFS_STATUS, 32'h0, RESP_OKAY);
    results();
  end
endmodule // i2c_event_status_upper_tb
